// ===== hdl/gpf_pkg.sv
// constants shared by the port E/F block and its property checks
package gpf_pkg;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte addresses
    localparam logic [7:0] ADR_E_DIRECTION = 8'h00;
    localparam logic [7:0] ADR_E_DATA = 8'h04;
    localparam logic [7:0] ADR_E_LATCH = 8'h08;
    localparam logic [7:0] ADR_F_DIRECTION = 8'h0c;
    localparam logic [7:0] ADR_F_DATA = 8'h10;
    localparam logic [7:0] ADR_F_LATCH = 8'h14;
    localparam logic [7:0] ADR_SLAVE_CTRL = 8'h18;
    localparam logic [7:0] ADR_F_ANALOG = 8'h1c;
    localparam logic [7:0] ADR_ALT_FUNC = 8'h20;
    // reset values
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [6:0] ANALOG_RESET = 7'h7f;
    localparam logic [3:0] ALT_RESET = 4'h0;
    // slave_port_control fields
    localparam int SPC_IBF = 7;
    localparam int SPC_OBF = 6;
    localparam int SPC_INPUT_OVERFLOW = 5;
    localparam int SPC_MODE = 4;
    // alternate function select fields
    localparam int ALT_CAPTURE_COMPARE_2 = 0;
    localparam int ALT_CMP2 = 1;
    localparam int ALT_CMP1 = 2;
    localparam int ALT_COMPARATOR_REF_OUT = 3;
    // pin positions
    localparam int PIN_E_RD = 0;
    localparam int PIN_E_WR = 1;
    localparam int PIN_E_CS = 2;
    localparam int PIN_E_CAPTURE_COMPARE_2 = 7;
    localparam int PIN_F_CMP2 = 1;
    localparam int PIN_F_CMP1 = 2;
    localparam int PIN_F_COMPARATOR_REF_OUT = 5;
    localparam int ANALOG_PINS = 7;
    localparam logic [2:0] PSP_CTRL_MASK = 3'h7;
endpackage : gpf_pkg

// ===== hdl/gpf_pin_if.sv
// signals between the register logic and one pin bank
`timescale 1ns/100ps
`default_nettype none
interface gpf_pin_if;
    logic [7:0] direction;
    logic [7:0] latch;
    logic [7:0] overrideEn;
    logic [7:0] overrideVal;
    logic [7:0] forceInput;
    logic [7:0] pinLevel;
    modport ctrl (output direction, latch, overrideEn, overrideVal, forceInput, input pinLevel);
    modport bank (input direction, latch, overrideEn, overrideVal, forceInput, output pinLevel);
endinterface : gpf_pin_if
`default_nettype wire

// ===== hdl/gpf_pin_bank.sv
// one 8-bit pin bank: input synchroniser and output driver per pin
`timescale 1ns/100ps
`default_nettype none
module gpf_pin_bank (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register side
    gpf_pin_if.bank ctl,
    // pins
    input wire logic [7:0] pinIn,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe
);
    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] out;
        logic [7:0] oe;
    } gpf_bank_s;

    gpf_bank_s st;
    gpf_bank_s next_st;
    wire logic [7:0] drive;
    wire logic [7:0] value;

    for (genvar i = 0; i < 8; i++) begin : g_pin
        // direction 1 floats the driver, 0 drives; a forced input wins over both
        assign drive[i] = ~ctl.direction[i] & ~ctl.forceInput[i]; // RL1 RL2 RL3 RL9
        // override value only steers the pin, the direction register is left alone
        assign value[i] = ctl.overrideEn[i] ? ctl.overrideVal[i] : ctl.latch[i]; // RL17
    end

    always_comb begin
        next_st = st;
        next_st.sync1 = pinIn;
        next_st.sync2 = st.sync1;
        // drive value is masked so an undriven pin never shows a stale latch bit
        next_st.out = drive & value;
        next_st.oe = drive;
        if (rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    assign ctl.pinLevel = st.sync2;
    assign pinOut = st.out;
    assign pinOe = st.oe;
endmodule // gpf_pin_bank
`default_nettype wire

// ===== hdl/gpf_ports.sv
// two 8-bit general purpose ports E and F behind a classic wishbone slave
// Operation
// (RL1) direction bit 1 makes port E pin input
// (RL2) direction bit 0 drives port E latch value
// (RL3) port E eight pins, each own direction
// (RL4) port E latch access uses latch, not pins
// (RL5) E pin0 is read strobe in slave mode
// (RL6) E pin1 is write strobe in slave mode
// (RL7) E pin2 is chip select in slave mode
// (RL8) E pin7 carries capture/compare 2 function
// (RL9) port F direction: 1 input, 0 drives latch
// (RL10) port F latch access uses latch, not pins
// (RL11) after reset F pins 6..0 inputs reading 0
// (RL12) software disables comparators, sets digital mode first
// (RL13) F pins 0..6 analog selectable, pin 7 digital
// (RL14) F1 outputs comparator 2, F2 comparator 1
// (RL15) F5 may present comparator reference output
// (RL16) slave select bit enables parallel slave mode
// (RL17) overrides never written into direction register
// (RL18) data reads pins, data writes update latch
// (RL19) direction resets to ones; latches keep value
`timescale 1ns/100ps
`default_nettype none
module gpf_ports (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // port E pins
    input wire logic [7:0] portEIn,
    output logic [7:0] portEOut,
    output logic [7:0] portEOe,
    // port F pins
    input wire logic [7:0] portFIn,
    output logic [7:0] portFOut,
    output logic [7:0] portFOe,
    // parallel slave port logic
    input wire logic inputBufferFull,
    input wire logic outputBufferFull,
    input wire logic inputOverflow,
    output logic parallelSlaveSelect,
    output logic slaveReadStrobe,
    output logic slaveWriteStrobe,
    output logic slaveChipSelect,
    // capture/compare 2
    input wire logic ccp2CompareOut,
    output logic ccp2CaptureIn,
    // comparators and converter
    input wire logic comparator1Out,
    input wire logic comparator2Out,
    output logic [6:0] analogSelect,
    output logic comparatorRefOutEnable
);
    typedef struct packed {
        logic [7:0] eDir;
        logic [7:0] eLatch;
        logic [7:0] fDir;
        logic [7:0] fLatch;
        logic parallel_slave_select;
        logic [6:0] fAnalog;
        logic [3:0] altFunc;
        logic ack;
        logic [31:0] rdata;
    } gpf_regs_s;

    gpf_regs_s st;
    gpf_regs_s next_st;

    gpf_pin_if eBus ();
    gpf_pin_if fBus ();

    logic req;
    logic wrByte;
    logic [7:0] wrData;
    logic [7:0] fDigitalLevel;
    logic [7:0] slaveCtrlRead;
    logic [31:0] readMux;

    assign req = wb_cyc_i & wb_stb_i;
    // only byte lane 0 carries register bits; the write lands on the acking edge
    assign wrByte = req & wb_we_i & st.ack & wb_sel_i[0];
    assign wrData = wb_dat_i[7:0];

    // analog pins have their digital input buffer off and read as zero
    assign fDigitalLevel = fBus.pinLevel & ~{1'b0, st.fAnalog}; // RL11 RL13

    always_comb begin
        slaveCtrlRead = '0;
        slaveCtrlRead[gpf_pkg::SPC_IBF] = inputBufferFull;
        slaveCtrlRead[gpf_pkg::SPC_OBF] = outputBufferFull;
        slaveCtrlRead[gpf_pkg::SPC_INPUT_OVERFLOW] = inputOverflow;
        slaveCtrlRead[gpf_pkg::SPC_MODE] = st.parallel_slave_select;
    end

    always_comb begin
        readMux = '0;
        if (wb_adr_i == gpf_pkg::ADR_E_DIRECTION) begin
            readMux[7:0] = st.eDir;
        end else if (wb_adr_i == gpf_pkg::ADR_E_DATA) begin
            readMux[7:0] = eBus.pinLevel; // RL18
        end else if (wb_adr_i == gpf_pkg::ADR_E_LATCH) begin
            readMux[7:0] = st.eLatch; // RL4
        end else if (wb_adr_i == gpf_pkg::ADR_F_DIRECTION) begin
            readMux[7:0] = st.fDir;
        end else if (wb_adr_i == gpf_pkg::ADR_F_DATA) begin
            readMux[7:0] = fDigitalLevel; // RL18
        end else if (wb_adr_i == gpf_pkg::ADR_F_LATCH) begin
            readMux[7:0] = st.fLatch; // RL10
        end else if (wb_adr_i == gpf_pkg::ADR_SLAVE_CTRL) begin
            readMux[7:0] = slaveCtrlRead;
        end else if (wb_adr_i == gpf_pkg::ADR_F_ANALOG) begin
            readMux[6:0] = st.fAnalog;
        end else if (wb_adr_i == gpf_pkg::ADR_ALT_FUNC) begin
            readMux[3:0] = st.altFunc;
        end
    end

    always_comb begin
        next_st = st;
        // ack for one cycle per request, then drop so the master can release
        next_st.ack = req & ~st.ack;
        if (req & ~st.ack) begin
            next_st.rdata = readMux;
        end
        if (wrByte) begin
            if (wb_adr_i == gpf_pkg::ADR_E_DIRECTION) begin
                next_st.eDir = wrData; // RL3
            end else if (wb_adr_i == gpf_pkg::ADR_E_DATA) begin
                next_st.eLatch = wrData; // RL18
            end else if (wb_adr_i == gpf_pkg::ADR_E_LATCH) begin
                next_st.eLatch = wrData; // RL4
            end else if (wb_adr_i == gpf_pkg::ADR_F_DIRECTION) begin
                next_st.fDir = wrData;
            end else if (wb_adr_i == gpf_pkg::ADR_F_DATA) begin
                next_st.fLatch = wrData; // RL18
            end else if (wb_adr_i == gpf_pkg::ADR_F_LATCH) begin
                next_st.fLatch = wrData; // RL10
            end else if (wb_adr_i == gpf_pkg::ADR_SLAVE_CTRL) begin
                next_st.parallel_slave_select = wrData[gpf_pkg::SPC_MODE]; // RL16
            end else if (wb_adr_i == gpf_pkg::ADR_F_ANALOG) begin
                next_st.fAnalog = wrData[6:0]; // RL13
            end else if (wb_adr_i == gpf_pkg::ADR_ALT_FUNC) begin
                next_st.altFunc = wrData[3:0];
            end
        end
        // latches are data, not control: no reset touches them
        if (rst) begin
            next_st.eDir = gpf_pkg::DIR_RESET; // RL19
            next_st.fDir = gpf_pkg::DIR_RESET; // RL11 RL19
            next_st.parallel_slave_select = 1'b0;
            next_st.fAnalog = gpf_pkg::ANALOG_RESET; // RL11
            next_st.altFunc = gpf_pkg::ALT_RESET;
            next_st.ack = 1'b0;
            next_st.rdata = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    // port E bank wiring
    always_comb begin
        eBus.direction = st.eDir;
        eBus.latch = st.eLatch;
        eBus.overrideEn = '0;
        eBus.overrideVal = '0;
        eBus.forceInput = '0;
        // slave mode takes the three control pins as inputs whatever the direction bits say
        eBus.forceInput[2:0] = st.parallel_slave_select ? gpf_pkg::PSP_CTRL_MASK : 3'h0; // RL5 RL6 RL7 RL16
        eBus.overrideEn[gpf_pkg::PIN_E_CAPTURE_COMPARE_2] = st.altFunc[gpf_pkg::ALT_CAPTURE_COMPARE_2]; // RL8
        eBus.overrideVal[gpf_pkg::PIN_E_CAPTURE_COMPARE_2] = ccp2CompareOut; // RL8
    end

    // port F bank wiring
    always_comb begin
        fBus.direction = st.fDir;
        fBus.latch = st.fLatch;
        fBus.overrideEn = '0;
        fBus.overrideVal = '0;
        fBus.forceInput = '0;
        fBus.overrideEn[gpf_pkg::PIN_F_CMP2] = st.altFunc[gpf_pkg::ALT_CMP2]; // RL14
        fBus.overrideVal[gpf_pkg::PIN_F_CMP2] = comparator2Out; // RL14
        fBus.overrideEn[gpf_pkg::PIN_F_CMP1] = st.altFunc[gpf_pkg::ALT_CMP1]; // RL14
        fBus.overrideVal[gpf_pkg::PIN_F_CMP1] = comparator1Out; // RL14
        // reference voltage is analog: the digital driver must stay off
        fBus.forceInput[gpf_pkg::PIN_F_COMPARATOR_REF_OUT] = st.altFunc[gpf_pkg::ALT_COMPARATOR_REF_OUT]; // RL15
    end

    gpf_pin_bank u_bank_e (
        .sys_clk(sys_clk),
        .rst(rst),
        .ctl(eBus),
        .pinIn(portEIn),
        .pinOut(portEOut),
        .pinOe(portEOe)
    );

    gpf_pin_bank u_bank_f (
        .sys_clk(sys_clk),
        .rst(rst),
        .ctl(fBus),
        .pinIn(portFIn),
        .pinOut(portFOut),
        .pinOe(portFOe)
    );

    // software must clear comparator and analog use before relying on digital F pins
    assign analogSelect = st.fAnalog; // RL12 RL13
    assign comparatorRefOutEnable = st.altFunc[gpf_pkg::ALT_COMPARATOR_REF_OUT]; // RL15

    // control inputs only mean something in slave mode; idle level otherwise
    assign parallelSlaveSelect = st.parallel_slave_select; // RL16
    assign slaveReadStrobe = st.parallel_slave_select & eBus.pinLevel[gpf_pkg::PIN_E_RD]; // RL5
    assign slaveWriteStrobe = st.parallel_slave_select & eBus.pinLevel[gpf_pkg::PIN_E_WR]; // RL6
    assign slaveChipSelect = st.parallel_slave_select & eBus.pinLevel[gpf_pkg::PIN_E_CS]; // RL7
    assign ccp2CaptureIn = eBus.pinLevel[gpf_pkg::PIN_E_CAPTURE_COMPARE_2]; // RL8

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
endmodule // gpf_ports
`default_nettype wire

// ===== sim/gpf_board.sv
// board model: each pin follows its driver when enabled, else the external level
`timescale 1ns/100ps
`default_nettype none
module gpf_board (
    // block drivers
    input wire logic [7:0] eOut,
    input wire logic [7:0] eOe,
    input wire logic [7:0] fOut,
    input wire logic [7:0] fOe,
    // external levels
    input wire logic [7:0] eExt,
    input wire logic [7:0] fExt,
    // pin levels
    output logic [7:0] eIn,
    output logic [7:0] fIn
);
    // no pull resistors: a released pin shows what the board applies
    assign eIn = (eOut & eOe) | (eExt & ~eOe);
    assign fIn = (fOut & fOe) | (fExt & ~fOe);
endmodule // gpf_board
`default_nettype wire

// ===== sim/gpf_ports_properties.sv
// concurrent checks on the port E/F block ports
`timescale 1ns/100ps
`default_nettype none
module gpf_ports_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // pins and peripherals
    input wire logic [7:0] portEIn,
    input wire logic [7:0] portEOut,
    input wire logic [7:0] portEOe,
    input wire logic [7:0] portFOut,
    input wire logic [7:0] portFOe,
    input wire logic parallelSlaveSelect,
    input wire logic slaveReadStrobe,
    input wire logic slaveWriteStrobe,
    input wire logic slaveChipSelect,
    input wire logic ccp2CaptureIn,
    input wire logic [6:0] analogSelect,
    input wire logic comparatorRefOutEnable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence wr_s(logic [7:0] a);
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == a ##1 wb_ack_o;
    endsequence
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    idle_low_a: assert property ((portEOut & ~portEOe) == 8'h0 && (portFOut & ~portFOe) == 8'h0) else $error("idle drive");
    e_dir_a: assert property (wr_s(gpf_pkg::ADR_E_DIRECTION) |-> ##3 portEOe[7:3] == ~$past(wb_dat_i[7:3], 3)) else $error("E oe");
    f_dir_a: assert property (wr_s(gpf_pkg::ADR_F_DIRECTION) |-> ##3 portFOe[4:0] == ~$past(wb_dat_i[4:0], 3)) else $error("F oe");
    slave_input_a: assert property (parallelSlaveSelect && $past(parallelSlaveSelect) |-> portEOe[2:0] == 3'h0) else $error("E2:0 oe");
    strobe_gate_a: assert property (!parallelSlaveSelect && !$past(parallelSlaveSelect) |-> !(slaveReadStrobe | slaveWriteStrobe | slaveChipSelect)) else $error("strobe");
    ref_input_a: assert property (comparatorRefOutEnable && $past(comparatorRefOutEnable) |-> !portFOe[5]) else $error("F5 oe");
    reset_state_a: assert property (disable iff (1'b0) rst |=> portEOe == 8'h0 && portFOe == 8'h0 && analogSelect == 7'h7f) else $error("reset");
    capture_path_a: assert property (!($past(rst) || $past(rst, 2) || $past(rst, 3)) |-> ccp2CaptureIn == $past(portEIn[7], 2)) else $error("capture");
endmodule // gpf_ports_properties
bind gpf_ports gpf_ports_properties u_props (.*);
`default_nettype wire

// ===== sim/gpf_ports_bench.sv
// self-checking bench for the port E/F block
`timescale 1ns/100ps
`default_nettype none
module gpf_ports_bench;
    logic sysClk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h0, eExt = 8'h81, fExt = 8'hff, v, eIn, eOut, eOe, fIn, fOut, fOe;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, input_buffer_full = 1'b1, output_buffer_full = 1'b0, input_overflow = 1'b1, ccpOut = 1'b0, cmp1 = 1'b0, cmp2 = 1'b0;
    logic pss, rdS, wrS, csS, ccpIn, refEn;
    logic [6:0] anSel;
    int n_fail = 0, checked = 0;
    always #2.5 sysClk = ~sysClk;
    gpf_ports u_dut (.sys_clk(sysClk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .portEIn(eIn), .portEOut(eOut), .portEOe(eOe), .portFIn(fIn), .portFOut(fOut), .portFOe(fOe),
        .inputBufferFull(input_buffer_full), .outputBufferFull(output_buffer_full), .inputOverflow(input_overflow), .parallelSlaveSelect(pss),
        .slaveReadStrobe(rdS), .slaveWriteStrobe(wrS), .slaveChipSelect(csS), .ccp2CompareOut(ccpOut),
        .ccp2CaptureIn(ccpIn), .comparator1Out(cmp1), .comparator2Out(cmp2), .analogSelect(anSel),
        .comparatorRefOutEnable(refEn));
    gpf_board u_board (.eOut(eOut), .eOe(eOe), .fOut(fOut), .fOe(fOe), .eExt(eExt), .fExt(fExt),
        .eIn(eIn), .fIn(fIn));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge sysClk);
    endtask
    // one classic cycle; read data lands in v
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge sysClk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        for (i = 0; i < 16; i++) begin
            @(posedge sysClk);
            if (ack === 1'b1) break;
        end
        if (i == 16) begin
            n_fail++;
            wrap_up();
        end
        v = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h0);
        chk(v, exp);
    endtask
    initial begin
        ticks(4);
        rst <= 1'b0;
        ticks(3);
        rd(8'h00, 8'hff);
        rd(8'h0c, 8'hff);
        rd(8'h10, 8'h80);
        rd(8'h1c, 8'h7f);
        rd(8'h18, 8'ha0);
        rd(8'h24, 8'h00);
        bus(1'b1, 8'h08, 8'h5a);
        bus(1'b1, 8'h00, 8'h03);
        ticks(3);
        chk(eOe, 8'hfc);
        chk(eOut, 8'h58);
        rd(8'h04, 8'h59);
        rd(8'h08, 8'h5a);
        bus(1'b1, 8'h04, 8'ha5);
        rd(8'h08, 8'ha5);
        bus(1'b1, 8'h00, 8'h00);
        eExt <= 8'h05;
        bus(1'b1, 8'h18, 8'h10);
        ticks(3);
        chk(eOe, 8'hf8);
        chk({4'h0, pss, csS, wrS, rdS}, 8'h0d);
        rd(8'h00, 8'h00);
        rd(8'h18, 8'hb0);
        bus(1'b1, 8'h18, 8'h00);
        bus(1'b1, 8'h20, 8'h01);
        ticks(4);
        chk({6'h0, eOut[7], ccpIn}, 8'h00);
        ccpOut <= 1'b1;
        ticks(4);
        chk({6'h0, eOut[7], ccpIn}, 8'h03);
        bus(1'b1, 8'h1c, 8'h00);
        bus(1'b1, 8'h14, 8'h3c);
        bus(1'b1, 8'h0c, 8'h00);
        bus(1'b1, 8'h20, 8'h0e);
        cmp2 <= 1'b1;
        ticks(3);
        chk(fOut, 8'h1a);
        chk(fOe, 8'hdf);
        chk({anSel, refEn}, 8'h01);
        rd(8'h14, 8'h3c);
        rd(8'h10, 8'h3a);
        bus(1'b1, 8'h1c, 8'h7f);
        rd(8'h10, 8'h00);
        rst <= 1'b1;
        ticks(2);
        rst <= 1'b0;
        ticks(3);
        rd(8'h08, 8'ha5);
        rd(8'h00, 8'hff);
        wrap_up();
    end
endmodule // gpf_ports_bench
`default_nettype wire
